// *** hdl/fault_line_params.svh ***
`ifndef FAULT_LINE_PARAMS_SVH
`define FAULT_LINE_PARAMS_SVH

// Byte offsets on the register bus; each 48-bit word is split low/high.
`define FLL_OFF_OPEN_SEL_LO 8'h00
`define FLL_OFF_OPEN_SEL_HI 8'h04
`define FLL_OFF_SHORT_SEL_LO 8'h08
`define FLL_OFF_SHORT_SEL_HI 8'h0c
`define FLL_OFF_OPEN_UP_LO 8'h10
`define FLL_OFF_OPEN_UP_HI 8'h14
`define FLL_OFF_OPEN_LOW_LO 8'h18
`define FLL_OFF_OPEN_LOW_HI 8'h1c
`define FLL_OFF_SHORT_UP_LO 8'h20
`define FLL_OFF_SHORT_UP_HI 8'h24
`define FLL_OFF_IRQ_STATUS 8'h28
`define FLL_OFF_IRQ_MASK 8'h2c

// Field layout and reset values.
`define FLL_SEL_W 6
`define FLL_SEL_RESET 6'h00
`define FLL_LINES 64
`define FLL_UPPER_BASE 48
`define FLL_UPPER_LINES 16
`define FLL_IRQ_W 2
`define FLL_IRQ_OPEN_BIT 0
`define FLL_IRQ_SHORT_BIT 1
`define FLL_IRQ_RESET 2'h0

// Bus answers.
`define FLL_RESP_OKAY 2'h0
`define FLL_RESP_SLVERR 2'h2

`endif

// *** hdl/fault_line_pkg.sv ***
package fault_line_pkg;

  typedef enum logic [3:0]
  {
    SEL_OPEN_SEL_LO = 4'b0000,
    SEL_OPEN_SEL_HI = 4'b0001,
    SEL_SHORT_SEL_LO = 4'b0010,
    SEL_SHORT_SEL_HI = 4'b0011,
    SEL_OPEN_UP_LO = 4'b0100,
    SEL_OPEN_UP_HI = 4'b0101,
    SEL_OPEN_LOW_LO = 4'b0110,
    SEL_OPEN_LOW_HI = 4'b0111,
    SEL_SHORT_UP_LO = 4'b1000,
    SEL_SHORT_UP_HI = 4'b1001,
    SEL_IRQ_STATUS = 4'b1010,
    SEL_IRQ_MASK = 4'b1011,
    SEL_NONE = 4'b1111
  } reg_sel_t;

  typedef logic [47:0] word48_t;

endpackage

// *** hdl/warn_capture.sv ***
`timescale 1ns/1ps

// Registers a warning bitmap from the fault detectors and flags new warnings.
module warn_capture
#(
  parameter int WIDTH = 16
)
(
  input wire logic i_core_clk,
  input wire logic i_reset_n,
  input wire logic [WIDTH-1:0] i_fault,
  output logic [WIDTH-1:0] o_map,
  output logic o_new_warning
);

  if (WIDTH < 1 || WIDTH > 64)
  begin : g_width_check
    $error("warn_capture: WIDTH must be 1 to 64");
  end

  // The map mirrors the detectors; only this process ever writes it.
  always_ff @(posedge i_core_clk)
  begin
    if (!i_reset_n)
    begin
      o_map <= '0;
    end
    else
    begin
      o_map <= i_fault;
    end
  end

  // A pulse for any line whose warning has just appeared.
  always_ff @(posedge i_core_clk)
  begin
    if (!i_reset_n)
    begin
      o_new_warning <= 1'b0;
    end
    else
    begin
      o_new_warning <= |(i_fault & ~o_map);
    end
  end

endmodule

// *** hdl/led_fault_line_locator_regs.sv ***
// Function
// - R/W 6-bit open-load line selector, bits 5..0; code equals line.
// - R/W 6-bit short-circuit line selector, resets zero; code is line.
// - Read-only 16-bit open-load map; bit n flags line 48 plus n.
// - Read-only 48-bit open-load map; bit n flags line n.
// - Read-only short-circuit map of lines 48..63; bit n flags 48+n.
//
// Chosen here: the AXI4-Lite register port and the address map.
`timescale 1ns/1ps
`include "fault_line_params.svh"

module led_fault_line_locator_regs
(
  input wire logic i_core_clk,
  input wire logic i_reset_n,
  input wire logic [7:0] i_awaddr,
  input wire logic i_awvalid,
  output logic o_awready,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  input wire logic i_wvalid,
  output logic o_wready,
  output logic [1:0] o_bresp,
  output logic o_bvalid,
  input wire logic i_bready,
  input wire logic [7:0] i_araddr,
  input wire logic i_arvalid,
  output logic o_arready,
  output logic [31:0] o_rdata,
  output logic [1:0] o_rresp,
  output logic o_rvalid,
  input wire logic i_rready,
  input wire logic [`FLL_LINES-1:0] i_open_line_fault,
  input wire logic [`FLL_UPPER_LINES-1:0] i_short_upper_fault,
  output logic [`FLL_SEL_W-1:0] o_open_line_selector,
  output logic [`FLL_SEL_W-1:0] o_short_line_selector,
  output fault_line_pkg::reg_sel_t o_last_read_sel,
  output logic o_irq
);

  import fault_line_pkg::*;

  function automatic reg_sel_t decode(input logic [7:0] addr);
    case (addr)
      `FLL_OFF_OPEN_SEL_LO: decode = SEL_OPEN_SEL_LO;
      `FLL_OFF_OPEN_SEL_HI: decode = SEL_OPEN_SEL_HI;
      `FLL_OFF_SHORT_SEL_LO: decode = SEL_SHORT_SEL_LO;
      `FLL_OFF_SHORT_SEL_HI: decode = SEL_SHORT_SEL_HI;
      `FLL_OFF_OPEN_UP_LO: decode = SEL_OPEN_UP_LO;
      `FLL_OFF_OPEN_UP_HI: decode = SEL_OPEN_UP_HI;
      `FLL_OFF_OPEN_LOW_LO: decode = SEL_OPEN_LOW_LO;
      `FLL_OFF_OPEN_LOW_HI: decode = SEL_OPEN_LOW_HI;
      `FLL_OFF_SHORT_UP_LO: decode = SEL_SHORT_UP_LO;
      `FLL_OFF_SHORT_UP_HI: decode = SEL_SHORT_UP_HI;
      `FLL_OFF_IRQ_STATUS: decode = SEL_IRQ_STATUS;
      `FLL_OFF_IRQ_MASK: decode = SEL_IRQ_MASK;
      default: decode = SEL_NONE;
    endcase
  endfunction

  logic [`FLL_LINES-1:0] open_map;
  logic [`FLL_UPPER_LINES-1:0] short_map;
  logic open_new;
  logic short_new;
  logic aw_held;
  logic w_held;
  reg_sel_t aw_sel;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic wr_fire;
  logic rd_fire;
  reg_sel_t rd_sel;
  logic [`FLL_IRQ_W-1:0] irq_status;
  logic [`FLL_IRQ_W-1:0] irq_mask;
  logic [`FLL_IRQ_W-1:0] irq_event;
  logic status_read;
  word48_t open_sel_word;
  word48_t short_sel_word;
  word48_t open_up_word;
  word48_t open_low_word;
  word48_t short_up_word;
  logic [31:0] next_rdata;

  warn_capture
  #(
    .WIDTH(`FLL_LINES)
  )
  open_capture
  (
    .i_core_clk(i_core_clk),
    .i_reset_n(i_reset_n),
    .i_fault(i_open_line_fault),
    .o_map(open_map),
    .o_new_warning(open_new)
  );

  warn_capture
  #(
    .WIDTH(`FLL_UPPER_LINES)
  )
  short_capture
  (
    .i_core_clk(i_core_clk),
    .i_reset_n(i_reset_n),
    .i_fault(i_short_upper_fault),
    .o_map(short_map),
    .o_new_warning(short_new)
  );

  // Address and data are each held once taken, in either order.
  assign o_awready = !aw_held && !o_bvalid;
  assign o_wready = !w_held && !o_bvalid;
  assign wr_fire = aw_held && w_held && !o_bvalid;
  assign o_arready = !o_rvalid;
  assign rd_fire = i_arvalid && o_arready;
  assign rd_sel = decode(i_araddr);

  always_ff @(posedge i_core_clk)
  begin
    if (!i_reset_n)
    begin
      aw_held <= 1'b0;
      aw_sel <= SEL_NONE;
    end
    else if (i_awvalid && o_awready)
    begin
      aw_held <= 1'b1;
      aw_sel <= decode(i_awaddr);
    end
    else if (wr_fire)
    begin
      aw_held <= 1'b0;
    end
  end

  always_ff @(posedge i_core_clk)
  begin
    if (!i_reset_n)
    begin
      w_held <= 1'b0;
      w_data <= 32'h0;
      w_strb <= 4'h0;
    end
    else if (i_wvalid && o_wready)
    begin
      w_held <= 1'b1;
      w_data <= i_wdata;
      w_strb <= i_wstrb;
    end
    else if (wr_fire)
    begin
      w_held <= 1'b0;
    end
  end

  // Writes to the maps are answered OKAY but change nothing.
  always_ff @(posedge i_core_clk)
  begin
    if (!i_reset_n)
    begin
      o_bvalid <= 1'b0;
      o_bresp <= `FLL_RESP_OKAY;
    end
    else if (wr_fire)
    begin
      o_bvalid <= 1'b1;
      o_bresp <= (aw_sel == SEL_NONE) ? `FLL_RESP_SLVERR : `FLL_RESP_OKAY;
    end
    else if (i_bready)
    begin
      o_bvalid <= 1'b0;
    end
  end

  always_ff @(posedge i_core_clk)
  begin
    if (!i_reset_n)
    begin
      o_open_line_selector <= `FLL_SEL_RESET;
    end
    else if (wr_fire && aw_sel == SEL_OPEN_SEL_LO && w_strb[0])
    begin
      o_open_line_selector <= w_data[`FLL_SEL_W-1:0];
    end
  end

  always_ff @(posedge i_core_clk)
  begin
    if (!i_reset_n)
    begin
      o_short_line_selector <= `FLL_SEL_RESET;
    end
    else if (wr_fire && aw_sel == SEL_SHORT_SEL_LO && w_strb[0])
    begin
      o_short_line_selector <= w_data[`FLL_SEL_W-1:0];
    end
  end

  always_ff @(posedge i_core_clk)
  begin
    if (!i_reset_n)
    begin
      irq_mask <= `FLL_IRQ_RESET;
    end
    else if (wr_fire && aw_sel == SEL_IRQ_MASK && w_strb[0])
    begin
      irq_mask <= w_data[`FLL_IRQ_W-1:0];
    end
  end

  // A new warning in the cycle of a status read survives the clear.
  assign irq_event = {short_new, open_new};
  assign status_read = rd_fire && rd_sel == SEL_IRQ_STATUS;

  always_ff @(posedge i_core_clk)
  begin
    if (!i_reset_n)
    begin
      irq_status <= `FLL_IRQ_RESET;
    end
    else
    begin
      irq_status <= (status_read ? `FLL_IRQ_RESET : irq_status) | irq_event;
    end
  end

  assign o_irq = |(irq_status & irq_mask);

  // Reserved positions are zero-filled here so they always read as zero.
  assign open_sel_word = {42'h0, o_open_line_selector};
  assign short_sel_word = {42'h0, o_short_line_selector};
  assign open_up_word = {32'h0, open_map[`FLL_LINES-1:`FLL_UPPER_BASE]};
  assign open_low_word = open_map[`FLL_UPPER_BASE-1:0];
  assign short_up_word = {32'h0, short_map};

  always_comb
  begin
    case (rd_sel)
      SEL_OPEN_SEL_LO: next_rdata = open_sel_word[31:0];
      SEL_OPEN_SEL_HI: next_rdata = {16'h0, open_sel_word[47:32]};
      SEL_SHORT_SEL_LO: next_rdata = short_sel_word[31:0];
      SEL_SHORT_SEL_HI: next_rdata = {16'h0, short_sel_word[47:32]};
      SEL_OPEN_UP_LO: next_rdata = open_up_word[31:0];
      SEL_OPEN_UP_HI: next_rdata = {16'h0, open_up_word[47:32]};
      SEL_OPEN_LOW_LO: next_rdata = open_low_word[31:0];
      SEL_OPEN_LOW_HI: next_rdata = {16'h0, open_low_word[47:32]};
      SEL_SHORT_UP_LO: next_rdata = short_up_word[31:0];
      SEL_SHORT_UP_HI: next_rdata = {16'h0, short_up_word[47:32]};
      SEL_IRQ_STATUS: next_rdata = {30'h0, irq_status};
      SEL_IRQ_MASK: next_rdata = {30'h0, irq_mask};
      default: next_rdata = 32'h0;
    endcase
  end

  always_ff @(posedge i_core_clk)
  begin
    if (!i_reset_n)
    begin
      o_rvalid <= 1'b0;
      o_rdata <= 32'h0;
      o_rresp <= `FLL_RESP_OKAY;
      o_last_read_sel <= SEL_NONE;
    end
    else if (rd_fire)
    begin
      o_rvalid <= 1'b1;
      o_rdata <= next_rdata;
      o_rresp <= (rd_sel == SEL_NONE) ? `FLL_RESP_SLVERR : `FLL_RESP_OKAY;
      o_last_read_sel <= rd_sel;
    end
    else if (i_rready)
    begin
      o_rvalid <= 1'b0;
    end
  end

  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (!i_reset_n);

  open_sel_write_a: assert property (
    wr_fire && aw_sel == SEL_OPEN_SEL_LO && w_strb[0]
    |=> o_open_line_selector == $past(w_data[5:0]) && o_bvalid)
    else $error("open-load selector did not take the written code");

  short_sel_reset_a: assert property (
    @(posedge i_core_clk) disable iff (1'b0)
    !i_reset_n |=> o_short_line_selector == `FLL_SEL_RESET)
    else $error("short-circuit selector not zero after reset");

  short_sel_write_a: assert property (
    wr_fire && aw_sel == SEL_SHORT_SEL_LO && w_strb[0]
    |=> o_short_line_selector == $past(w_data[5:0]) && o_bvalid)
    else $error("short-circuit selector write lost");

  open_upper_read_a: assert property (
    rd_fire && rd_sel == SEL_OPEN_UP_LO
    |=> o_rvalid && o_rdata == {16'h0, $past(open_map[63:48])})
    else $error("upper open-load map read wrong");

  open_lower_read_a: assert property (
    rd_fire && rd_sel == SEL_OPEN_LOW_HI
    |=> o_rdata == {16'h0, $past(open_map[47:32])})
    else $error("lower open-load map high half read wrong");

  short_upper_read_a: assert property (
    rd_fire && rd_sel == SEL_SHORT_UP_LO
    |=> o_rdata == {16'h0, $past(short_map)} && o_rresp == 2'h0)
    else $error("upper short-circuit map read wrong");

  map_follows_fault_a: assert property (
    $past(i_reset_n) |-> open_map == $past(i_open_line_fault)
    && short_map == $past(i_short_upper_fault))
    else $error("warning map changed by something other than detectors");

  reserved_zero_a: assert property (
    rd_fire && rd_sel == SEL_OPEN_SEL_LO |=> o_rdata[31:6] == 26'h0)
    else $error("reserved selector bits read nonzero");

  irq_status_clear_a: assert property (
    status_read && !(|irq_event) |=> irq_status == 2'h0 && !o_irq)
    else $error("status read did not clear interrupt");

  open_write_cover: cover property (
    wr_fire && aw_sel == SEL_OPEN_SEL_LO ##[1:3] o_bvalid && i_bready);
  map_read_cover: cover property (rd_fire && rd_sel == SEL_OPEN_LOW_LO);
  irq_raise_cover: cover property (!o_irq ##1 o_irq);
  unmapped_cover: cover property (rd_fire && rd_sel == SEL_NONE);

endmodule

// *** dv/tb_led_fault_line_locator_regs.sv ***
`timescale 1ns/1ps
`include "fault_line_params.svh"

module tb_led_fault_line_locator_regs;
  import fault_line_pkg::*;

  typedef struct
  {
    logic [7:0] a;
    logic wr;
    logic [31:0] d;
    logic [1:0] r;
  } row_t;

  logic i_core_clk = 1'b0;
  logic i_reset_n = 1'b0;
  logic [7:0] i_awaddr = 8'h00;
  logic i_awvalid = 1'b0;
  logic [31:0] i_wdata = 32'h0;
  logic [3:0] i_wstrb = 4'h0;
  logic i_wvalid = 1'b0;
  logic i_bready = 1'b0;
  logic [7:0] i_araddr = 8'h00;
  logic i_arvalid = 1'b0;
  logic i_rready = 1'b0;
  logic [63:0] i_open_line_fault = 64'h0;
  logic [15:0] i_short_upper_fault = 16'h0;
  logic o_awready, o_wready, o_bvalid, o_arready, o_rvalid, o_irq;
  logic [1:0] o_bresp, o_rresp;
  logic [31:0] o_rdata;
  logic [5:0] o_open_line_selector, o_short_line_selector;
  reg_sel_t o_last_read_sel;
  int n_fail = 0;
  int num_checks = 0;
  row_t rows [16];

  led_fault_line_locator_regs u_led_fault_line_locator_regs
  (
    .i_core_clk(i_core_clk), .i_reset_n(i_reset_n),
    .i_awaddr(i_awaddr), .i_awvalid(i_awvalid), .o_awready(o_awready),
    .i_wdata(i_wdata), .i_wstrb(i_wstrb), .i_wvalid(i_wvalid),
    .o_wready(o_wready), .o_bresp(o_bresp), .o_bvalid(o_bvalid),
    .i_bready(i_bready), .i_araddr(i_araddr), .i_arvalid(i_arvalid),
    .o_arready(o_arready), .o_rdata(o_rdata), .o_rresp(o_rresp),
    .o_rvalid(o_rvalid), .i_rready(i_rready),
    .i_open_line_fault(i_open_line_fault),
    .i_short_upper_fault(i_short_upper_fault),
    .o_open_line_selector(o_open_line_selector),
    .o_short_line_selector(o_short_line_selector),
    .o_last_read_sel(o_last_read_sel), .o_irq(o_irq)
  );

  initial
  begin
    forever #50 i_core_clk = ~i_core_clk;
  end

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    num_checks++;
    if (g !== e)
    begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Address and data are offered together and each is dropped once taken.
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
                        input logic [1:0] er, input logic [3:0] s = 4'hf);
    bit aw;
    bit w;
    @(posedge i_core_clk);
    i_awaddr <= a;
    i_awvalid <= 1'b1;
    i_wdata <= d;
    i_wstrb <= s;
    i_wvalid <= 1'b1;
    aw = 1;
    w = 1;
    while (aw || w)
    begin
      @(posedge i_core_clk);
      if (aw && o_awready === 1'b1)
      begin
        aw = 0;
        i_awvalid <= 1'b0;
      end
      if (w && o_wready === 1'b1)
      begin
        w = 0;
        i_wvalid <= 1'b0;
      end
    end
    i_bready <= 1'b1;
    do @(posedge i_core_clk); while (o_bvalid !== 1'b1);
    chk("bresp", er, o_bresp);
    i_bready <= 1'b0;
  endtask

  task automatic axi_rd(input logic [7:0] a, input logic [31:0] e,
                        input logic [1:0] er);
    @(posedge i_core_clk);
    i_araddr <= a;
    i_arvalid <= 1'b1;
    do @(posedge i_core_clk); while (o_arready !== 1'b1);
    i_arvalid <= 1'b0;
    i_rready <= 1'b1;
    do @(posedge i_core_clk); while (o_rvalid !== 1'b1);
    chk($sformatf("rdata %h", a), e, o_rdata);
    chk("rresp", er, o_rresp);
    i_rready <= 1'b0;
  endtask

  task automatic test_done;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  initial
  begin
    repeat (6000) @(posedge i_core_clk);
    n_fail++;
    test_done();
  end

  initial
  begin
    rows = '{
      '{`FLL_OFF_OPEN_SEL_LO, 1, 32'h0000003f, `FLL_RESP_OKAY},
      '{`FLL_OFF_OPEN_SEL_LO, 0, 32'h0000003f, `FLL_RESP_OKAY},
      '{`FLL_OFF_OPEN_SEL_HI, 0, 32'h0, `FLL_RESP_OKAY},
      '{`FLL_OFF_SHORT_SEL_LO, 1, 32'hffffffff, `FLL_RESP_OKAY},
      '{`FLL_OFF_SHORT_SEL_LO, 0, 32'h0000003f, `FLL_RESP_OKAY},
      '{`FLL_OFF_SHORT_SEL_LO, 1, 32'h0000001f, `FLL_RESP_OKAY},
      '{`FLL_OFF_SHORT_SEL_LO, 0, 32'h0000001f, `FLL_RESP_OKAY},
      '{`FLL_OFF_OPEN_UP_LO, 0, 32'h00008001, `FLL_RESP_OKAY},
      '{`FLL_OFF_OPEN_UP_HI, 0, 32'h0, `FLL_RESP_OKAY},
      '{`FLL_OFF_OPEN_LOW_LO, 1, 32'h0, `FLL_RESP_OKAY},
      '{`FLL_OFF_OPEN_LOW_LO, 0, 32'h12345678, `FLL_RESP_OKAY},
      '{`FLL_OFF_OPEN_LOW_HI, 0, 32'h0000a5a5, `FLL_RESP_OKAY},
      '{8'h30, 1, 32'h00000001, `FLL_RESP_SLVERR},
      '{8'h30, 0, 32'h0, `FLL_RESP_SLVERR},
      '{`FLL_OFF_SHORT_UP_LO, 0, 32'h00004002, `FLL_RESP_OKAY},
      '{`FLL_OFF_SHORT_UP_HI, 0, 32'h0, `FLL_RESP_OKAY}
    };
    repeat (2) @(posedge i_core_clk);
    i_reset_n <= 1'b1;
    axi_rd(`FLL_OFF_IRQ_STATUS, 32'h0, `FLL_RESP_OKAY);
    i_open_line_fault <= 64'h8001_a5a5_1234_5678;
    i_short_upper_fault <= 16'h4002;
    repeat (3) @(posedge i_core_clk);
    foreach (rows[i])
      if (rows[i].wr)
        axi_wr(rows[i].a, rows[i].d, rows[i].r);
      else
        axi_rd(rows[i].a, rows[i].d, rows[i].r);
    chk("open_sel", 32'h3f, o_open_line_selector);
    chk("short_sel", 32'h1f, o_short_line_selector);
    chk("last_sel", SEL_SHORT_UP_HI, o_last_read_sel);
    // Both new warnings are pending but the mask still hides them.
    chk("irq", 32'h0, o_irq);
    axi_wr(`FLL_OFF_IRQ_MASK, 32'h3, `FLL_RESP_OKAY);
    chk("irq", 32'h1, o_irq);
    axi_rd(`FLL_OFF_IRQ_STATUS, 32'h3, `FLL_RESP_OKAY);
    chk("irq", 32'h0, o_irq);
    axi_rd(`FLL_OFF_IRQ_STATUS, 32'h0, `FLL_RESP_OKAY);
    axi_wr(`FLL_OFF_IRQ_MASK, 32'h1, `FLL_RESP_OKAY);
    i_short_upper_fault <= 16'hc002;
    repeat (3) @(posedge i_core_clk);
    chk("irq", 32'h0, o_irq);
    axi_rd(`FLL_OFF_SHORT_UP_LO, 32'h0000c002, `FLL_RESP_OKAY);
    axi_rd(`FLL_OFF_IRQ_STATUS, 32'h2, `FLL_RESP_OKAY);
    i_open_line_fault <= 64'h0001_a5a5_1234_567a;
    repeat (3) @(posedge i_core_clk);
    chk("irq", 32'h1, o_irq);
    axi_rd(`FLL_OFF_OPEN_LOW_LO, 32'h1234567a, `FLL_RESP_OKAY);
    axi_rd(`FLL_OFF_OPEN_UP_LO, 32'h00000001, `FLL_RESP_OKAY);
    axi_rd(`FLL_OFF_IRQ_STATUS, 32'h1, `FLL_RESP_OKAY);
    chk("irq", 32'h0, o_irq);
    // Byte lane 0 is off, so the selector must keep its code.
    axi_wr(`FLL_OFF_SHORT_SEL_LO, 32'h2a, `FLL_RESP_OKAY,
           4'he);
    chk("short_sel strb", 32'h1f, o_short_line_selector);
    // A second reset in mid-run must bring every writable field back.
    @(posedge i_core_clk);
    i_reset_n <= 1'b0;
    repeat (2) @(posedge i_core_clk);
    i_reset_n <= 1'b1;
    @(posedge i_core_clk);
    chk("open_sel rst", 32'h0, o_open_line_selector);
    chk("short_sel rst", 32'h0, o_short_line_selector);
    chk("last_sel rst", SEL_NONE, o_last_read_sel);
    chk("irq rst", 32'h0, o_irq);
    chk("bvalid rst", 32'h0, o_bvalid);
    axi_rd(`FLL_OFF_OPEN_SEL_LO, 32'h0, `FLL_RESP_OKAY);
    axi_rd(`FLL_OFF_SHORT_SEL_LO, 32'h0, `FLL_RESP_OKAY);
    axi_rd(`FLL_OFF_IRQ_MASK, 32'h0, `FLL_RESP_OKAY);
    test_done();
  end
endmodule
